// ### bench/sbwwc_asserts.sv
// Port assertions for the wake wait control
`timescale 1ns/1ps
`default_nettype none
module sbwwc_asserts
(
    // Clock, reset, bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic [3:0] adr_i,
    input wire logic [7:0] dat_o,
    input wire logic       ack_o,
    input wire logic       err_o,
    // Wait engine and watch sampling strobe
    input wire logic       wake_req_i,
    input wire logic       switch_req_i,
    input wire logic       ext_clk_sel_o,
    input wire logic       wait_busy_o,
    input wire logic       watch_sample_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [18:0] busy_ff;
    wire         req  = wake_req_i | switch_req_i;
    wire         take = cyc_i & stb_i & ~ack_o & ~err_o;
    // Longest legal wait is twice the largest count; a restart clears it
    always @(posedge clk_i)
        busy_ff <= (rst_i | ~wait_busy_o | req) ? 19'h0 : busy_ff + 19'h1;
    property p_ack; take |=> (ack_o ^ err_o) ##1 !(ack_o | err_o); endproperty
    a_ack: assert property (p_ack) else $error("bus answer wrong");
    property p_err; take && adr_i != 4'h0 && adr_i != 4'h4 |=> err_o; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_start; req |=> wait_busy_o && !ext_clk_sel_o; endproperty
    a_start: assert property (p_start) else $error("wait not started");
    property p_excl; ext_clk_sel_o != wait_busy_o; endproperty
    a_excl: assert property (p_excl) else $error("clock used during wait");
    property p_min; req |=> !ext_clk_sel_o [*8]; endproperty
    a_min: assert property (p_min) else $error("wait too short");
    property p_max; busy_ff <= 19'h40000; endproperty
    a_max: assert property (p_max) else $error("wait too long");
    property p_watch; watch_sample_en_o |=> !watch_sample_en_o [*3]; endproperty
    a_watch: assert property (p_watch) else $error("sample pulse too soon");
    property p_rsv; ack_o && $past(adr_i) == 4'h0 |-> dat_o[2:0] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // sbwwc_asserts
`default_nettype wire

// ### bench/sbwwc_top_tb.sv
// Self-checking bench for the wake wait control
`timescale 1ns/1ps
`default_nettype none
module sbwwc_top_tb;
    logic       clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic       wake_req_i = 1'b0, switch_req_i = 1'b0, e;
    logic [3:0] adr_i = 4'h0;
    logic [7:0] dat_i = 8'h00, q, d;
    wire  [7:0] dat_o;
    wire        ack_o, err_o, ext_clk_sel_o, wait_busy_o, standby_on_sleep_o, watch_sample_en_o;
    integer     mismatches = 0, tests_run = 0, seed = 32'he635b5d5, n, i;
    always #2 clk_i = ~clk_i;
    sbwwc_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(1'b1), .dat_i,
        .dat_o, .ack_o, .err_o, .wake_req_i, .switch_req_i, .ext_clk_sel_o, .wait_busy_o,
        .standby_on_sleep_o, .watch_sample_en_o);
    function automatic integer states(input logic [2:0] c);
        states = (c < 3'h5) ? (8192 << c) : (16 << (3 * (3'h7 - c)));
    endfunction
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x)
        begin
            mismatches++;
            $display("MISMATCH %s exp %0h seen %0h", nm, x, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= v;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (n < 20 && !(ack_o | err_o));
        q = dat_o;
        e = err_o;
        check("answer", ack_o | err_o, 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (!(ack_o | e))
            report_and_stop();
    endtask
    task automatic wake(input logic sw, input integer x);
        @(posedge clk_i);
        wake_req_i <= !sw;
        switch_req_i <= sw;
        @(posedge clk_i);
        wake_req_i <= 1'b0;
        switch_req_i <= 1'b0;
        n = 0;
        do @(negedge clk_i); while (!ext_clk_sel_o && ++n < 300000);
        check("wait", n, x);
        check("busy", wait_busy_o, 1'b0);
        if (n == 300000)
            report_and_stop();
    endtask
    task automatic period(input integer x);
        repeat (3)
        begin
            n = 0;
            do @(negedge clk_i); while (++n < 40 && !watch_sample_en_o);
        end
        check("watch", n, x);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 4'h0, 8'h00);
        check("reg0", q, 8'h00);
        wb(0, 4'h4, 8'h00);
        check("status", q, 8'h01);
        wb(1, 4'h8, 8'hff);
        check("unmapped", e, 1'b1);
        for (i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h07 : 8'($random(seed));
            wb(1, 4'h0, d);
            wb(0, 4'h0, 8'h00);
            check("reg0", q, d & 8'hf8);
            check("sleep", standby_on_sleep_o, d[7]);
        end
        // Long codes cost run time, so only code 0 is taken of those
        for (i = 5; i < 8; i++)
        begin
            wb(1, 4'h0, {1'b0, i[2:0], 4'h0});
            wake(1'b0, states(i[2:0]));
        end
        wb(1, 4'h0, 8'h00);
        wake(1'b1, states(3'h0));
        wb(1, 4'h0, 8'h70);
        @(posedge clk_i);
        switch_req_i <= 1'b1;
        @(posedge clk_i);
        switch_req_i <= 1'b0;
        wb(0, 4'h4, 8'h00);
        check("status", q, 8'h02);
        repeat (20) @(posedge clk_i);
        wb(0, 4'h4, 8'h00);
        check("status", q, 8'h01);
        wb(1, 4'h0, 8'h08);
        period(4);
        wb(1, 4'h0, 8'h00);
        period(16);
        report_and_stop();
    end
endmodule // sbwwc_top_tb
bind sbwwc_top sbwwc_asserts chk (.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .dat_o, .ack_o,
    .err_o, .wake_req_i, .switch_req_i, .ext_clk_sel_o, .wait_busy_o, .watch_sample_en_o);
`default_nettype wire

// ### hdl/sbwwc_map.vh
// Register map, field positions, reset values and wait codes for the wake wait control
`ifndef SBWWC_MAP_VH
`define SBWWC_MAP_VH

`define SBWWC_PDC1_OFFSET      4'h0
`define SBWWC_STATUS_OFFSET    4'h4
`define SBWWC_PDC1_RESET       8'h00
`define SBWWC_STANDBY_BIT      7
`define SBWWC_WAIT_MSB         6
`define SBWWC_WAIT_LSB         4
`define SBWWC_SAMPLE_BIT       3
`define SBWWC_PDC1_WMASK       8'hf8
`define SBWWC_DIV_SLOW         5'h10
`define SBWWC_DIV_FAST         5'h04
`define SBWWC_STATES_0         18'h02000
`define SBWWC_STATES_1         18'h04000
`define SBWWC_STATES_2         18'h08000
`define SBWWC_STATES_3         18'h10000
`define SBWWC_STATES_4         18'h20000
`define SBWWC_STATES_5         18'h00400
`define SBWWC_STATES_6         18'h00080
`define SBWWC_STATES_7         18'h00010

`endif

// ### hdl/sbwwc_top.v
// Standby wake wait control with classic Wishbone register slave
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sbwwc_map.vh"

// Summary of operation
// - Bits 6..4 pick the wait after oscillator start before its clock is used.
// - During the wait the on-chip clock is used; count, then switch over.
// - The same code sets the wait when software switches to the external clock.
// - Counted wait lies between the programmed count and twice that count.
// - Bit 3 picks watch clock sampling: 0 is divide by 16, 1 divide by 4.
// - Bits 2..0 reset to zero, read zero and ignore writes.
// - Reset clears wait select and sample select; both read and write.
// - Codes 0..7 give 8192,16384,32768,65536,131072,1024,128,16 wait states.
// - Bit 7 picks sleep (0) or standby (1) for the sleep instruction.
module sbwwc_top
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [0:0]  sel_i,
    input  wire [7:0]  dat_i,
    output wire [7:0]  dat_o,
    output wire        ack_o,
    output wire        err_o,
    // Wake and switch requests, one-cycle pulses from same-clock logic
    input  wire        wake_req_i,
    input  wire        switch_req_i,
    // Clock selection, watch sampling and standby select
    output wire        ext_clk_sel_o,
    output wire        wait_busy_o,
    output wire        standby_on_sleep_o,
    output wire        watch_sample_en_o
);

    localparam [1:0] ST_EXT  = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    // Register slave
    reg  [7:0]  pdc1_ff;
    reg  [7:0]  dat_ff;
    reg         ack_ff;
    reg         err_ff;
    reg  [7:0]  nxt_rdata;
    reg         nxt_hit;

    // Wait engine
    reg  [1:0]  state_ff;
    reg  [17:0] wait_cnt_ff;
    reg  [17:0] wait_target_ff;
    reg         ext_sel_ff;
    reg         busy_ff;

    // Watch sampling and standby select
    reg         stby_ff;
    reg  [4:0]  div_cnt_ff;
    reg         sample_ff;

    wire        req_valid = cyc_i & stb_i & ~ack_ff & ~err_ff;
    wire        hit_pdc1  = (adr_i == `SBWWC_PDC1_OFFSET);
    wire        hit_stat  = (adr_i == `SBWWC_STATUS_OFFSET);
    wire        start     = wake_req_i | switch_req_i;
    wire [4:0]  div_last  = pdc1_ff[`SBWWC_SAMPLE_BIT] ? `SBWWC_DIV_FAST - 5'h01
                                                       : `SBWWC_DIV_SLOW - 5'h01;

    // Wait states for a code
    function [17:0] wait_states;
        input [2:0] code;
        begin
            case (code)
                3'h0: wait_states = `SBWWC_STATES_0;
                3'h1: wait_states = `SBWWC_STATES_1;
                3'h2: wait_states = `SBWWC_STATES_2;
                3'h3: wait_states = `SBWWC_STATES_3;
                3'h4: wait_states = `SBWWC_STATES_4;
                3'h5: wait_states = `SBWWC_STATES_5;
                3'h6: wait_states = `SBWWC_STATES_6;
                default: wait_states = `SBWWC_STATES_7;
            endcase
        end
    endfunction

    // Address decode; the status word is read-only, writes to it are acked and dropped
    always @*
    begin
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b0;
        if (hit_pdc1)
        begin
            nxt_rdata = pdc1_ff;
            nxt_hit   = 1'b1;
        end
        else if (hit_stat)
        begin
            nxt_rdata = {6'h00, busy_ff, ext_sel_ff};
            nxt_hit   = 1'b1;
        end
    end

    // Register slave, one wait cycle free: ack follows the request edge
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pdc1_ff <= `SBWWC_PDC1_RESET;
            dat_ff  <= 8'h00;
            ack_ff  <= 1'b0;
            err_ff  <= 1'b0;
        end
        else
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            dat_ff <= 8'h00;
            if (req_valid)
            begin
                if (!nxt_hit)
                    err_ff <= 1'b1;
                else
                begin
                    ack_ff <= 1'b1;
                    if (!we_i)
                        dat_ff <= nxt_rdata;
                    else if (hit_pdc1 && sel_i[0])
                        pdc1_ff <= dat_i & `SBWWC_PDC1_WMASK;
                end
            end
        end
    end

    // Stabilization wait: runs on the on-chip clock until the count ends
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff       <= ST_EXT;
            wait_cnt_ff    <= 18'h00000;
            wait_target_ff <= 18'h00000;
            ext_sel_ff     <= 1'b1;
            busy_ff        <= 1'b0;
        end
        else if (start)
        begin
            // Code is latched at request; later writes do not stretch a running wait
            state_ff       <= ST_WAIT;
            wait_cnt_ff    <= 18'h00000;
            // Held as count minus one so the compare needs no subtractor
            wait_target_ff <= wait_states(pdc1_ff[`SBWWC_WAIT_MSB:`SBWWC_WAIT_LSB])
                              - 18'h00001;
            ext_sel_ff     <= 1'b0;
            busy_ff        <= 1'b1;
        end
        else
        begin
            case (state_ff)
                ST_WAIT:
                begin
                    if (wait_cnt_ff == wait_target_ff)
                    begin
                        // Exactly the programmed count, inside one to two times it
                        state_ff   <= ST_EXT;
                        ext_sel_ff <= 1'b1;
                        busy_ff    <= 1'b0;
                    end
                    else
                        wait_cnt_ff <= wait_cnt_ff + 18'h00001;
                end
                default:
                begin
                    state_ff <= ST_EXT;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // Watch clock sampling strobe and standby select register
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_cnt_ff <= 5'h00;
            sample_ff  <= 1'b0;
            stby_ff    <= 1'b0;
        end
        else
        begin
            stby_ff <= pdc1_ff[`SBWWC_STANDBY_BIT];
            if (div_cnt_ff >= div_last)
            begin
                div_cnt_ff <= 5'h00;
                sample_ff  <= 1'b1;
            end
            else
            begin
                div_cnt_ff <= div_cnt_ff + 5'h01;
                sample_ff  <= 1'b0;
            end
        end
    end

    assign dat_o              = dat_ff;
    assign ack_o              = ack_ff;
    assign err_o              = err_ff;
    assign ext_clk_sel_o      = ext_sel_ff;
    assign wait_busy_o        = busy_ff;
    assign standby_on_sleep_o = stby_ff;
    assign watch_sample_en_o  = sample_ff;

endmodule // sbwwc_top

`default_nettype wire
